// ### src/ckss_pkg.sv
// Shared constants, field layouts and types for the clock select and standby controller
package ckss_pkg;

   // Register bus geometry
   localparam int WB_ADR_W = 18;
   localparam int WB_DAT_W = 32;

   // Register indices; the byte address is four times the index
   localparam logic [15:0] IDX_OSC_SRC = 16'h7f0a;
   localparam logic [15:0] IDX_CLK_DIV = 16'h7f0b;
   localparam logic [15:0] IDX_PLL = 16'h7f88;
   localparam logic [15:0] IDX_STATUS = 16'h7f89;

   // Reset values
   localparam logic [7:0] RST_OSC_SRC = 8'h00;
   localparam logic [7:0] RST_CLK_DIV = 8'h00;
   localparam logic [7:0] RST_PLL = 8'h00;

   // Readable-bit masks; reserved bits read as zero
   localparam logic [7:0] MASK_CLK_DIV = 8'hb7;
   localparam logic [7:0] MASK_PLL = 8'hbf;

   // Internal source codes of the clock switch
   localparam logic [1:0] SRC_RC = 2'h0;
   localparam logic [1:0] SRC_MAIN = 2'h1;
   localparam logic [1:0] SRC_SUB = 2'h2;

   // Codes of the system clock select field
   localparam logic [1:0] SEL_SUB = 2'h3;
   localparam logic [1:0] SEL_MAIN = 2'h2;

   // PLL multiplier formula terms
   localparam logic [8:0] PLL_STEP = 9'h038;
   localparam logic [8:0] PLL_COARSE_OFS = 9'h003;

   // Base timer divide exponent for code 00 (1/32)
   localparam logic [3:0] BT_DIV_EXP_BASE = 4'h5;

   // Oscillator source control register layout
   typedef struct packed {
      logic main_osc_type_hi;
      logic [1:0] system_clock_source_select;
      logic rc_osc_stop;
      logic main_osc_type_lo;
      logic sub_osc_type;
      logic main_osc_enable;
      logic sub_osc_enable;
   } ckss_osc_src_t;

   // Clock divider and timer clock register layout
   typedef struct packed {
      logic base_timer_clock_source;
      logic rsv6;
      logic [1:0] base_timer_divide_select;
      logic rsv3;
      logic [2:0] system_clock_divide;
   } ckss_clk_div_t;

   // PLL control register layout
   typedef struct packed {
      logic test_mode;
      logic rsv6;
      logic [1:0] pll_fine_multiplier;
      logic [1:0] pll_coarse_multiplier;
      logic supply_3v;
      logic pll_run;
   } ckss_pll_t;

   // Standby modes
   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h1,
      MODE_IDLE = 4'h2,
      MODE_DEEP = 4'h4,
      MODE_DEEP_KEEP = 4'h8
   } ckss_mode_t;

   // Clock switch phases
   typedef enum logic [2:0] {
      SW_STEADY = 3'h1,
      SW_WAIT_OLD = 3'h2,
      SW_WAIT_NEW = 3'h4
   } ckss_sw_t;

endpackage : ckss_pkg

// ### src/ckss_clk_switch.sv
// Glitch-free selector between the three oscillator tick streams
`timescale 1ns/100ps
`default_nettype none
module ckss_clk_switch
   import ckss_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [2:0] osc_tick,
   input wire logic [1:0] req_src,
   output logic [1:0] cur_src,
   output logic src_tick,
   output logic busy
);
   ckss_sw_t sw_r;
   logic [1:0] new_src_r;

   // Phase of a switch: settle on an old edge, then on a new edge
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         sw_r <= SW_STEADY;
         cur_src <= SRC_RC;
         new_src_r <= SRC_RC;
      end
      else
      begin
         unique case (sw_r)
            SW_STEADY:
            begin
               if (req_src != cur_src)
               begin
                  new_src_r <= req_src;
                  sw_r <= SW_WAIT_OLD;
               end
            end
            SW_WAIT_OLD:
            begin
               if (osc_tick[cur_src])
                  sw_r <= SW_WAIT_NEW;
            end
            SW_WAIT_NEW:
            begin
               if (osc_tick[new_src_r])
               begin
                  cur_src <= new_src_r;
                  sw_r <= SW_STEADY;
               end
            end
            default:
               sw_r <= SW_STEADY;
         endcase
      end
   end

   // Ticks are blocked while a switch is in flight, so no runt period escapes
   assign src_tick = (sw_r == SW_STEADY) && osc_tick[cur_src];
   assign busy = (sw_r != SW_STEADY);
endmodule : ckss_clk_switch
`default_nettype wire

// ### src/ckss_tick_div.sv
// Power-of-two tick divider that takes a new ratio only at the end of a period
`timescale 1ns/100ps
`default_nettype none
module ckss_tick_div
   import ckss_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic in_tick,
   input wire logic [3:0] div_exp,
   output logic out_tick
);
   logic [7:0] count_r;
   logic [3:0] exp_r;
   logic [8:0] last;

   // Terminal count of the ratio now in force
   assign last = 9'((9'h001 << exp_r) - 9'h001);

   // Count input ticks; reload the ratio on wrap to keep periods whole
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         count_r <= 8'h00;
         exp_r <= 4'h0;
      end
      else if (in_tick)
      begin
         if ({1'b0, count_r} >= last)
         begin
            count_r <= 8'h00;
            exp_r <= div_exp;
         end
         else
            count_r <= 8'(count_r + 8'h01);
      end
   end

   assign out_tick = in_tick && ({1'b0, count_r} >= last);
endmodule : ckss_tick_div
`default_nettype wire

// ### src/ckss_ctrl.sv
// Clock source selection, divider control and standby sequencing with a Wishbone slave
`timescale 1ns/100ps
`default_nettype none
module ckss_ctrl
   import ckss_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   // Wishbone classic slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [WB_ADR_W-1:0] wb_adr,
   input wire logic [WB_DAT_W-1:0] wb_dat_w,
   input wire logic [3:0] wb_sel,
   output logic [WB_DAT_W-1:0] wb_dat_r,
   output logic wb_ack,
   // Oscillator outputs as seen on pins, unsynchronised
   input wire logic main_osc_pin,
   input wire logic sub_osc_pin,
   input wire logic rc_osc_pin,
   // CPU core side, same clock
   input wire logic idle_instr,
   input wire logic deep_sleep_instr,
   input wire logic deep_keep_instr,
   input wire logic irq_pending,
   input wire logic irq_accept_enable,
   input wire logic irq_accepted,
   input wire logic wake_release,
   // Oscillator control
   output logic main_osc_run,
   output logic main_osc_ceramic,
   output logic main_osc_vco,
   output logic sub_osc_run,
   output logic sub_pins_crystal,
   output logic rc_osc_run,
   output logic pll_run_out,
   output logic [8:0] pll_multiplier,
   output logic pll_supply_3v,
   // Clock and standby outputs
   output logic sys_clk_tick,
   output logic base_timer_tick,
   output logic cpu_halt,
   output logic periph_run,
   output logic sub_periph_run
);

   ckss_osc_src_t osc_src_r;
   ckss_clk_div_t clk_div_r;
   ckss_pll_t pll_r;
   ckss_mode_t mode_r;
   ckss_mode_t mode_nxt;
   logic wb_ack_r;
   logic [WB_DAT_W-1:0] wb_dat_r_r;
   logic req;
   logic wr_strobe;
   logic [15:0] idx;
   logic [7:0] rd_byte;
   logic [2:0] osc_pin;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;
   logic [2:0] osc_tick;
   logic [1:0] req_src;
   logic [1:0] cur_src;
   logic src_tick;
   logic sw_busy;
   logic sys_tick;
   logic bt_div_tick;
   logic enter_deep;
   logic leave_keep;
   logic keep_main_en_r;
   logic keep_rc_stop_r;
   logic [1:0] keep_sel_r;
   logic osc_hold;
   logic main_osc_run_r;
   logic main_osc_ceramic_r;
   logic main_osc_vco_r;
   logic sub_osc_run_r;
   logic sub_pins_crystal_r;
   logic rc_osc_run_r;
   logic pll_run_out_r;
   logic [8:0] pll_multiplier_r;
   logic pll_supply_3v_r;
   logic sys_clk_tick_r;
   logic base_timer_tick_r;
   logic cpu_halt_r;
   logic periph_run_r;
   logic sub_periph_run_r;

   // Bus decode: register index sits above the byte offset
   assign req = wb_cyc && wb_stb && !wb_ack_r;
   assign idx = wb_adr[WB_ADR_W-1:2];
   assign wr_strobe = req && wb_we && wb_sel[0];

   // Read multiplexer; unmapped indices read zero
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (idx)
         IDX_OSC_SRC: rd_byte = osc_src_r;
         IDX_CLK_DIV: rd_byte = clk_div_r & MASK_CLK_DIV;
         IDX_PLL: rd_byte = pll_r & MASK_PLL;
         IDX_STATUS: rd_byte = {sw_busy, 1'b0, cur_src, mode_r};
         default: rd_byte = 8'h00;
      endcase
   end

   // Single-cycle acknowledge, dropped the cycle after it is given
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         wb_ack_r <= 1'b0;
         wb_dat_r_r <= '0;
      end
      else
      begin
         wb_ack_r <= req;
         if (req)
            wb_dat_r_r <= {24'h000000, rd_byte};
      end
   end

   // Two-flop synchronisers and edge detect for the oscillator pins
   assign osc_pin[SRC_RC] = rc_osc_pin;
   assign osc_pin[SRC_MAIN] = main_osc_pin;
   assign osc_pin[SRC_SUB] = sub_osc_pin;
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_sync
         always_ff @(posedge core_clk or posedge reset)
         begin
            if (reset)
            begin
               sync1_r[i] <= 1'b0;
               sync2_r[i] <= 1'b0;
               sync3_r[i] <= 1'b0;
            end
            else
            begin
               sync1_r[i] <= osc_pin[i];
               sync2_r[i] <= sync1_r[i];
               sync3_r[i] <= sync2_r[i];
            end
         end
         assign osc_tick[i] = sync2_r[i] && !sync3_r[i];
      end
   endgenerate

   // Standby mode sequencing
   always_comb
   begin
      mode_nxt = mode_r;
      unique case (mode_r)
         MODE_NORMAL:
         begin
            if (idle_instr)
               mode_nxt = MODE_IDLE;
            else if (deep_sleep_instr || deep_keep_instr)
            begin
               if (irq_pending)
                  mode_nxt = irq_accept_enable ? MODE_NORMAL : MODE_IDLE;
               else if (deep_sleep_instr)
                  mode_nxt = MODE_DEEP;
               else
                  mode_nxt = MODE_DEEP_KEEP;
            end
         end
         MODE_IDLE:
         begin
            if (irq_accepted)
               mode_nxt = MODE_NORMAL;
         end
         MODE_DEEP:
         begin
            if (wake_release)
               mode_nxt = MODE_IDLE;
         end
         MODE_DEEP_KEEP:
         begin
            if (wake_release)
               mode_nxt = MODE_IDLE;
         end
         default:
            mode_nxt = MODE_NORMAL;
      endcase
   end

   // Mode register; the CPU is halted outside normal, so no new instruction lands
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         mode_r <= MODE_NORMAL;
      else
         mode_r <= mode_nxt;
   end

   assign enter_deep = (mode_r == MODE_NORMAL) && (mode_nxt == MODE_DEEP);
   assign leave_keep = (mode_r == MODE_DEEP_KEEP) && (mode_nxt != MODE_DEEP_KEEP);
   assign osc_hold = (mode_r == MODE_DEEP) || (mode_r == MODE_DEEP_KEEP);

   // Snapshot of the state that keep-sub sleep must hand back
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         keep_main_en_r <= 1'b0;
         keep_rc_stop_r <= 1'b0;
         keep_sel_r <= 2'h0;
      end
      else if ((mode_r == MODE_NORMAL) && (mode_nxt == MODE_DEEP_KEEP))
      begin
         keep_main_en_r <= osc_src_r.main_osc_enable;
         keep_rc_stop_r <= osc_src_r.rc_osc_stop;
         keep_sel_r <= osc_src_r.system_clock_source_select;
      end
   end

   // Oscillator source control; hardware loads win over a bus write
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         osc_src_r <= RST_OSC_SRC;
      else if (enter_deep)
         osc_src_r <= RST_OSC_SRC;
      else if (leave_keep)
      begin
         osc_src_r.main_osc_enable <= keep_main_en_r;
         osc_src_r.rc_osc_stop <= keep_rc_stop_r;
         osc_src_r.system_clock_source_select <= keep_sel_r;
      end
      else if (wr_strobe && (idx == IDX_OSC_SRC))
         osc_src_r <= wb_dat_w[7:0];
   end

   // Divider and base timer control; cleared on deep sleep entry
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         clk_div_r <= RST_CLK_DIV;
      else if (enter_deep)
         clk_div_r <= RST_CLK_DIV;
      else if (wr_strobe && (idx == IDX_CLK_DIV))
         clk_div_r <= wb_dat_w[7:0] & MASK_CLK_DIV;
   end

   // PLL control; coarse factor is held while the PLL runs
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         pll_r <= RST_PLL;
      else if (wr_strobe && (idx == IDX_PLL))
      begin
         pll_r.test_mode <= wb_dat_w[7];
         pll_r.pll_fine_multiplier <= wb_dat_w[5:4];
         if (!pll_r.pll_run)
            pll_r.pll_coarse_multiplier <= wb_dat_w[3:2];
         pll_r.supply_3v <= wb_dat_w[1];
         pll_r.pll_run <= wb_dat_w[0];
      end
   end

   // Map the select field onto a switch source code
   always_comb
   begin
      unique case (osc_src_r.system_clock_source_select)
         SEL_SUB: req_src = SRC_SUB;
         SEL_MAIN: req_src = SRC_MAIN;
         default: req_src = SRC_RC;
      endcase
   end

   // Glitch-free source switch
   ckss_clk_switch u_switch (
      .core_clk(core_clk),
      .reset(reset),
      .osc_tick(osc_tick),
      .req_src(req_src),
      .cur_src(cur_src),
      .src_tick(src_tick),
      .busy(sw_busy)
   );

   // System clock divider, ratio two to the code
   ckss_tick_div u_sys_div (
      .core_clk(core_clk),
      .reset(reset),
      .in_tick(src_tick),
      .div_exp({1'b0, clk_div_r.system_clock_divide}),
      .out_tick(sys_tick)
   );

   // Base timer divider on the system clock, 1/32 to 1/256
   ckss_tick_div u_bt_div (
      .core_clk(core_clk),
      .reset(reset),
      .in_tick(sys_tick),
      .div_exp(4'(BT_DIV_EXP_BASE + {2'b00, clk_div_r.base_timer_divide_select})),
      .out_tick(bt_div_tick)
   );

   // Oscillator run controls, gated by the standby mode
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         main_osc_run_r <= 1'b0;
         main_osc_ceramic_r <= 1'b0;
         main_osc_vco_r <= 1'b0;
         sub_osc_run_r <= 1'b0;
         sub_pins_crystal_r <= 1'b0;
         rc_osc_run_r <= 1'b0;
         pll_run_out_r <= 1'b0;
      end
      else
      begin
         main_osc_ceramic_r <= osc_src_r.main_osc_type_hi && osc_src_r.main_osc_type_lo;
         main_osc_vco_r <= osc_src_r.main_osc_type_hi && !osc_src_r.main_osc_type_lo;
         // Pair 00 and the forbidden 01 both leave the main oscillator idle
         main_osc_run_r <= osc_src_r.main_osc_enable && osc_src_r.main_osc_type_hi
                           && !osc_hold;
         sub_pins_crystal_r <= osc_src_r.sub_osc_type;
         sub_osc_run_r <= osc_src_r.sub_osc_enable && osc_src_r.sub_osc_type
                          && (mode_r != MODE_DEEP);
         rc_osc_run_r <= !osc_src_r.rc_osc_stop && !osc_hold;
         pll_run_out_r <= pll_r.pll_run && !osc_hold;
      end
   end

   // PLL factor; the test bit plays no part in it
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         pll_multiplier_r <= 9'h000;
         pll_supply_3v_r <= 1'b0;
      end
      else
      begin
         pll_multiplier_r <= 9'(PLL_STEP * (PLL_COARSE_OFS + {7'h00, pll_r.pll_coarse_multiplier})
                             + {7'h00, pll_r.pll_fine_multiplier});
         pll_supply_3v_r <= pll_r.supply_3v;
      end
   end

   // Clock ticks and activity levels
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         sys_clk_tick_r <= 1'b0;
         base_timer_tick_r <= 1'b0;
         cpu_halt_r <= 1'b0;
         periph_run_r <= 1'b1;
         sub_periph_run_r <= 1'b1;
      end
      else
      begin
         sys_clk_tick_r <= sys_tick && !osc_hold;
         // Direct sub ticks keep the base timer alive in keep-sub sleep
         base_timer_tick_r <= clk_div_r.base_timer_clock_source
                              ? (bt_div_tick && !osc_hold)
                              : (osc_tick[SRC_SUB] && (mode_r != MODE_DEEP));
         cpu_halt_r <= (mode_r != MODE_NORMAL);
         periph_run_r <= (mode_r == MODE_NORMAL) || (mode_r == MODE_IDLE);
         sub_periph_run_r <= (mode_r != MODE_DEEP);
      end
   end

   // Outputs straight from flip-flops
   assign wb_ack = wb_ack_r;
   assign wb_dat_r = wb_dat_r_r;
   assign main_osc_run = main_osc_run_r;
   assign main_osc_ceramic = main_osc_ceramic_r;
   assign main_osc_vco = main_osc_vco_r;
   assign sub_osc_run = sub_osc_run_r;
   assign sub_pins_crystal = sub_pins_crystal_r;
   assign rc_osc_run = rc_osc_run_r;
   assign pll_run_out = pll_run_out_r;
   assign pll_multiplier = pll_multiplier_r;
   assign pll_supply_3v = pll_supply_3v_r;
   assign sys_clk_tick = sys_clk_tick_r;
   assign base_timer_tick = base_timer_tick_r;
   assign cpu_halt = cpu_halt_r;
   assign periph_run = periph_run_r;
   assign sub_periph_run = sub_periph_run_r;

endmodule : ckss_ctrl
`default_nettype wire

// ### dv/ckss_ctrl_asserts.sv
// Port checks for the clock select and standby controller
`timescale 1ns/100ps
`default_nettype none
module ckss_ctrl_chk (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_ack,
   input wire logic idle_instr,
   input wire logic deep_sleep_instr,
   input wire logic deep_keep_instr,
   input wire logic irq_pending,
   input wire logic irq_accept_enable,
   input wire logic irq_accepted,
   input wire logic wake_release,
   input wire logic main_osc_run,
   input wire logic main_osc_ceramic,
   input wire logic main_osc_vco,
   input wire logic rc_osc_run,
   input wire logic [8:0] pll_multiplier,
   input wire logic cpu_halt,
   input wire logic periph_run,
   input wire logic sub_periph_run
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // Sleep requests taken in normal mode; idle wins over both
   wire logic go_deep = !cpu_halt && deep_sleep_instr && !idle_instr;
   wire logic go_keep = !cpu_halt && deep_keep_instr && !idle_instr;
   chk_ack_answer: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("bus request not answered");
   chk_deep_entry: assert property (go_deep && !irq_pending |-> ##2 cpu_halt
      && !periph_run && !sub_periph_run ##1 !rc_osc_run && !main_osc_run)
      else $error("deep sleep entry wrong");
   chk_keep_entry: assert property (go_keep && !irq_pending |-> ##2 cpu_halt
      && !periph_run && sub_periph_run ##1 !rc_osc_run && !main_osc_run)
      else $error("keep-sub sleep entry wrong");
   chk_irq_normal: assert property ((go_deep || go_keep) && irq_pending
      && irq_accept_enable |=> !cpu_halt [*3]) else $error("pending request not honoured");
   chk_wake_idle: assert property (cpu_halt && !periph_run && wake_release
      |-> ##2 cpu_halt && periph_run) else $error("release did not give idle");
   chk_idle_exit: assert property (cpu_halt && periph_run && irq_accepted
      |-> ##2 !cpu_halt) else $error("idle not left");
   chk_pll_factor: assert property (!$past(reset) |-> pll_multiplier >= 9'h0a8
      && pll_multiplier <= 9'h153 && (pll_multiplier - 9'h0a8) % 9'h038 < 9'h004)
      else $error("pll factor out of set");
   chk_main_type: assert property (!(main_osc_ceramic && main_osc_vco)
      && (!main_osc_run || main_osc_ceramic || main_osc_vco)) else $error("main type wrong");
   cov_deep: cover property (go_deep && !irq_pending);
   cov_keep: cover property (go_keep && !irq_pending);
   cov_wake: cover property (wake_release && !sub_periph_run);
endmodule : ckss_ctrl_chk
bind ckss_ctrl ckss_ctrl_chk ckss_ctrl_chk_i (.core_clk, .reset, .wb_cyc, .wb_stb, .wb_ack,
   .idle_instr, .deep_sleep_instr, .deep_keep_instr, .irq_pending, .irq_accept_enable,
   .irq_accepted, .wake_release, .main_osc_run, .main_osc_ceramic, .main_osc_vco, .rc_osc_run,
   .pll_multiplier, .cpu_halt, .periph_run, .sub_periph_run);
`default_nettype wire

// ### dv/ckss_far_model.sv
// Far side model: CPU standby requests and the three oscillator pins
`timescale 1ns/100ps
`default_nettype none
module ckss_far_model (
   input wire logic core_clk,
   input wire logic [2:0] go,
   input wire logic main_osc_run,
   input wire logic pll_run_out,
   input wire logic sub_osc_run,
   input wire logic rc_osc_run,
   output logic [2:0] instr,
   output logic [2:0] osc_pin
);
   int n = 0;
   initial instr = 3'h0;
   initial osc_pin = 3'h0;
   // Standby instructions leave as one-cycle pulses, never two in a row
   always @(posedge core_clk)
   begin
      instr <= (instr == 3'h0) ? go : 3'h0;
   end
   // Running oscillators toggle at fixed rates; stopped ones hold their level
   always @(posedge core_clk)
   begin
      n <= n + 1;
      if ((main_osc_run || pll_run_out) && n % 3 == 0) osc_pin[0] <= !osc_pin[0];
      if (sub_osc_run && n % 5 == 0) osc_pin[1] <= !osc_pin[1];
      if (rc_osc_run && n % 2 == 0) osc_pin[2] <= !osc_pin[2];
   end
endmodule : ckss_far_model
`default_nettype wire

// ### dv/ckss_ctrl_tb.sv
// Self-checking bench for the clock select and standby controller
`timescale 1ns/100ps
`default_nettype none
module ckss_ctrl_tb;
   import ckss_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, wb_cyc = 1'b0, wb_we = 1'b0;
   logic irq_pending = 1'b0, irq_accept_enable = 1'b0, irq_accepted = 1'b0, wake_release = 1'b0;
   logic [17:0] wb_adr = 18'h00000;
   logic [31:0] wb_dat_w = 32'h0, wb_dat_r, lf = 32'h895f;
   logic [2:0] go = 3'h0, instr, pin;
   logic wb_ack, main_osc_run, main_osc_ceramic, main_osc_vco, sub_osc_run, sub_pins_crystal;
   logic rc_osc_run, pll_run_out, pll_supply_3v, sys_clk_tick, base_timer_tick, cpu_halt;
   logic periph_run, sub_periph_run;
   logic [8:0] pll_multiplier;
   logic [7:0] osc_m = 8'h00, div_m = 8'h00, pll_m = 8'h00, rd;
   logic [15:0] ix[4] = '{IDX_OSC_SRC, IDX_CLK_DIV, IDX_PLL, 16'h0123};
   int fail_count = 0, num_checks = 0, cyc_n = 0;
   ckss_ctrl ckss_ctrl_i (.core_clk, .reset, .wb_cyc, .wb_stb(wb_cyc), .wb_we, .wb_adr, .wb_dat_w,
      .wb_sel(4'hf), .wb_dat_r, .wb_ack, .main_osc_pin(pin[0]), .sub_osc_pin(pin[1]),
      .rc_osc_pin(pin[2]), .idle_instr(instr[0]), .deep_sleep_instr(instr[1]),
      .deep_keep_instr(instr[2]), .irq_pending, .irq_accept_enable, .irq_accepted, .wake_release,
      .main_osc_run, .main_osc_ceramic, .main_osc_vco, .sub_osc_run, .sub_pins_crystal,
      .rc_osc_run, .pll_run_out, .pll_multiplier, .pll_supply_3v, .sys_clk_tick,
      .base_timer_tick, .cpu_halt, .periph_run, .sub_periph_run);
   ckss_far_model ckss_far_model_i (.core_clk, .go, .main_osc_run, .pll_run_out, .sub_osc_run,
      .rc_osc_run, .instr, .osc_pin(pin));
   // Clock
   initial
   begin
      forever #5 core_clk = !core_clk;
   end
   // Hang guard
   always @(posedge core_clk)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 80000)
      begin
         fail_count++;
         results();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   // One classic bus cycle; reads other than status compared with the register model
   task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
      wb_adr <= {idx, 2'h0};
      wb_we <= w;
      wb_dat_w <= {24'h0, d};
      wb_cyc <= 1'b1;
      @(posedge core_clk);
      while (wb_ack !== 1'b1) @(posedge core_clk);
      wb_cyc <= 1'b0;
      rd = wb_dat_r[7:0];
      if (w && idx == IDX_OSC_SRC) osc_m = d;
      if (w && idx == IDX_CLK_DIV) div_m = d & MASK_CLK_DIV;
      if (w && idx == IDX_PLL) pll_m = (pll_m[0] ? {d[7:4], pll_m[3:2], d[1:0]} : d) & MASK_PLL;
      if (!w && idx != IDX_STATUS) check(wb_dat_r, idx == IDX_OSC_SRC ? osc_m : idx ==
         IDX_CLK_DIV ? div_m : idx == IDX_PLL ? pll_m : 8'h00);
      @(posedge core_clk);
   endtask : bus
   task automatic osc(input logic [7:0] v);
      bus(IDX_OSC_SRC, 1'b1, v);
      @(posedge core_clk);
      check({main_osc_ceramic, main_osc_vco, main_osc_run, sub_pins_crystal, sub_osc_run,
         rc_osc_run}, {v[7] & v[3], v[7] & !v[3], v[7] & v[1], v[2], v[2] & v[0], !v[4]});
   endtask : osc
   task automatic per(input logic bt, input int exp);
      int t0;
      repeat (3) @(posedge core_clk iff (bt ? base_timer_tick : sys_clk_tick));
      t0 = cyc_n;
      @(posedge core_clk iff (bt ? base_timer_tick : sys_clk_tick));
      check(cyc_n - t0, exp);
   endtask : per
   task automatic sleep(input logic [2:0] k);
      go <= k;
      @(posedge core_clk);
      go <= 3'h0;
      repeat (6) @(posedge core_clk);
   endtask : sleep
   task automatic hit(input bit w);
      {wake_release, irq_accepted} <= w ? 2'h2 : 2'h1;
      @(posedge core_clk);
      {wake_release, irq_accepted} <= 2'h0;
      repeat (6) @(posedge core_clk);
   endtask : hit
   // Main sequence
   initial
   begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({rc_osc_run, pll_multiplier}, {1'b1, 9'h0a8});
      bus(16'h0123, 1'b1, 8'hff);
      foreach (ix[i]) bus(ix[i], 1'b0, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         lf = lfsr(lf);
         bus(IDX_PLL, 1'b1, lf[7:0] & 8'h7e);
         bus(IDX_PLL, 1'b0, 8'h00);
         check({pll_supply_3v, pll_multiplier},
            {pll_m[1], 9'h038 * (pll_m[3:2] + 9'h003) + pll_m[5:4]});
      end
      bus(IDX_PLL, 1'b1, 8'h01);
      bus(IDX_PLL, 1'b1, 8'h2d);
      bus(IDX_PLL, 1'b0, 8'h00);
      check({pll_run_out, pll_multiplier}, {1'b1, 9'h0aa});
      bus(IDX_PLL, 1'b1, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         osc(8'h8f | 8'(c << 5));
         repeat (40) @(posedge core_clk);
         bus(IDX_STATUS, 1'b0, 8'h00);
         check({rd[7], rd[5:4]}, c == 3 ? 2 : c == 2 ? 1 : 0);
      end
      osc(8'h83);
      osc(8'h12);
      osc(8'h05);
      for (int c = 0; c < 8; c++)
      begin
         bus(IDX_CLK_DIV, 1'b1, 8'(c));
         per(1'b0, 4 << c);
      end
      for (int c = 0; c < 4; c++)
      begin
         bus(IDX_CLK_DIV, 1'b1, 8'h80 | 8'(c << 4));
         per(1'b1, 128 << c);
      end
      bus(IDX_CLK_DIV, 1'b1, 8'h30);
      per(1'b1, 10);
      sleep(3'h1);
      check({cpu_halt, periph_run, rc_osc_run}, 3'h7);
      hit(1'b0);
      check(cpu_halt, 1'b0);
      irq_pending <= 1'b1;
      irq_accept_enable <= 1'b1;
      sleep(3'h2);
      check(cpu_halt, 1'b0);
      irq_accept_enable <= 1'b0;
      sleep(3'h4);
      check({cpu_halt, periph_run}, 2'h3);
      irq_pending <= 1'b0;
      hit(1'b0);
      bus(IDX_CLK_DIV, 1'b1, 8'h33);
      sleep(3'h2);
      osc_m = 8'h00;
      div_m = 8'h00;
      check({cpu_halt, periph_run, sub_periph_run, rc_osc_run, sub_osc_run}, 5'h10);
      hit(1'b1);
      check({cpu_halt, periph_run, rc_osc_run}, 3'h7);
      bus(IDX_CLK_DIV, 1'b0, 8'h00);
      bus(IDX_OSC_SRC, 1'b0, 8'h00);
      bus(IDX_STATUS, 1'b0, 8'h00);
      check(rd[5:4], 2'h0);
      hit(1'b0);
      osc(8'hef);
      repeat (40) @(posedge core_clk);
      sleep(3'h4);
      check({cpu_halt, periph_run, sub_periph_run, sub_osc_run, main_osc_run, rc_osc_run},
         6'h2c);
      // A write during keep-sub sleep must lose its main enable, RC stop and select to the values saved at entry
      bus(IDX_OSC_SRC, 1'b1, 8'h95);
      hit(1'b1);
      osc_m = 8'he7; // Main enable, RC stop and select back to entry values
      check({cpu_halt, main_osc_run, rc_osc_run}, 3'h7);
      bus(IDX_OSC_SRC, 1'b0, 8'h00);
      results();
   end
endmodule : ckss_ctrl_tb
`default_nettype wire
